// *** rtl/poc_consts.svh ***
// offsets, field positions, reset values and timing counts of the pwm output controller
`ifndef POC_CONSTS_SVH
`define POC_CONSTS_SVH
`define POC_A_SWCFG   8'h02
`define POC_A_PWRREQ  8'h03
`define POC_A_LOOPPH  8'h53
`define POC_A_PINFN   8'h60
`define POC_A_PINRT   8'h64
`define POC_A_STATE   8'h68
`define POC_A_PHSEL   8'h6A
`define POC_A_SSEN    8'h6B
`define POC_A_SSRATE  8'h6C
`define POC_B_MONO    2
`define POC_B_CHSHIFT 0
`define POC_B_FASTTRI 2
`define POC_RST_REG   8'h00
`define POC_SS_ON     2'h3
`define POC_SYNC_ON   2'h3
`define POC_CLK_HZ    100000000
`define POC_FSW_HZ    768000
`define POC_PER_CYC   (`POC_CLK_HZ / `POC_FSW_HZ)
`define POC_DEV5      (`POC_PER_CYC * 5 / 200)
`define POC_DEV10     (`POC_PER_CYC * 10 / 200)
`define POC_DEV20     (`POC_PER_CYC * 20 / 200)
`define POC_DEV25     (`POC_PER_CYC * 25 / 200)
`define POC_TRI_MID   8
`define POC_SLOTS     8
`endif

// *** rtl/poc_core.sv ***
// pwm output stage control: mapping, spread spectrum, phase, power state, modulation
// Operation
// - one bit of switching config picks stereo bridge or paralleled mono
// - stereo: left drives pair A, right drives pair B independently
// - mono: left sample feeds both output pairs
// - spread spectrum only when enable register has both bits set
// - rate code: bit 2 picks 24k or 48k triangle, low bits spread 5-25%
// - bit 0 of loop/phase register shifts channel B by 180 degrees
// - four phase slots, neighbouring slots 45 degrees apart
// - clock alignment: audio clock restarts while in hiz, device aligns itself
// - play request with sync waits in hiz, readback shows hiz
// - rising edge on sync pin moves waiting devices into play
// - state 00 deep sleep, outputs off
// - state 01 sleep, outputs off
// - state 10 only output drivers in high impedance
// - state 11 play, also straight from deep sleep
// - three-level: outputs rail to rail, in phase at zero input
// - positive value: positive duty above half, negative below
// - negative value: positive duty below half, negative above
`timescale 1ns/10ps
`include "poc_consts.svh"
module poc_core (
	input  wire logic              sys_clk,     // 100 MHz clock
	input  wire logic              rstn,        // async reset, active low
	input  wire logic              clkEn,       // freezes all state except the reset synchroniser when low
	input  wire logic              regWr,       // register write strobe
	input  wire logic              regRd,       // register read strobe
	input  wire logic [7:0]        regAddr,     // register offset
	input  wire logic [7:0]        regWrData,   // write data
	output logic [7:0]             regRdData,   // read data, one cycle after regRd
	input  wire logic [15:0]       leftSample,  // signed left audio sample
	input  wire logic [15:0]       rightSample, // signed right audio sample
	input  wire logic              bitClkOn,    // audio bit clock present
	input  wire logic              sync_input_pin, // shared phase sync line
	output poc_pkg::poc_out_t      pwmOut,      // pwm pins and driver enables
	output poc_pkg::poc_pm_t       powerState   // current operating state
);
	logic [1:0]          rstSync_r;
	logic                rstOk;
	poc_pkg::poc_state_t st_r;
	poc_pkg::poc_state_t st_nxt;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rstSync_r <= 2'h0;
		end else begin
			rstSync_r <= {rstSync_r[0], 1'b1};
		end
	end
	assign rstOk = rstSync_r[1];

	function automatic logic [7:0] devOf(input logic [1:0] code);
		if (code == 2'h0) begin
			devOf = 8'(`POC_DEV5);
		end else if (code == 2'h1) begin
			devOf = 8'(`POC_DEV10);
		end else if (code == 2'h2) begin
			devOf = 8'(`POC_DEV20);
		end else begin
			devOf = 8'(`POC_DEV25);
		end
	endfunction

	function automatic logic [7:0] ampOf(input logic [15:0] s);
		ampOf = {{2{s[15]}}, s[15:10]};
	endfunction

	// one decode of the offset serves both the write and the read path
	function automatic logic [3:0] regIdx(input logic [7:0] a);
		if (a == `POC_A_SWCFG) begin
			regIdx = 4'h0;
		end else if (a == `POC_A_PWRREQ) begin
			regIdx = 4'h1;
		end else if (a == `POC_A_LOOPPH) begin
			regIdx = 4'h2;
		end else if (a == `POC_A_PINFN) begin
			regIdx = 4'h3;
		end else if (a == `POC_A_PINRT) begin
			regIdx = 4'h4;
		end else if (a == `POC_A_PHSEL) begin
			regIdx = 4'h5;
		end else if (a == `POC_A_SSEN) begin
			regIdx = 4'h6;
		end else if (a == `POC_A_SSRATE) begin
			regIdx = 4'h7;
		end else if (a == `POC_A_STATE) begin
			regIdx = 4'h8;
		end else begin
			regIdx = 4'hF;
		end
	endfunction

	function automatic logic [7:0] rdMux(
		input poc_pkg::poc_regs_t r,
		input poc_pkg::poc_pm_t   pm,
		input logic [3:0]         idx
	);
		if (idx == 4'h0) begin
			rdMux = r.swCfg;
		end else if (idx == 4'h1) begin
			rdMux = r.pwrReq;
		end else if (idx == 4'h2) begin
			rdMux = r.loopPh;
		end else if (idx == 4'h3) begin
			rdMux = r.pinFn;
		end else if (idx == 4'h4) begin
			rdMux = r.pinRt;
		end else if (idx == 4'h5) begin
			rdMux = r.phSel;
		end else if (idx == 4'h6) begin
			rdMux = r.ssEn;
		end else if (idx == 4'h7) begin
			rdMux = r.ssRate;
		end else if (idx == 4'h8) begin
			rdMux = {6'h00, pm};
		end else begin
			rdMux = 8'h00;
		end
	endfunction

	// clkPrev starts high so a bit clock already running at reset is no restart
	localparam poc_pkg::poc_state_t ST_RST = '{
		regs:     '0,
		pm:       poc_pkg::PM_DEEP,
		cnt:      8'h00,
		triPh:    5'h00,
		perLen:   8'(`POC_PER_CYC),
		ampA:     8'h00,
		ampB:     8'h00,
		syncPrev: 1'b0,
		clkPrev:  1'b1,
		rdData:   8'h00,
		out:      '0
	};

	logic               mono;
	logic               ssOn;
	logic               syncEn;
	logic               pinSync;
	logic               syncRise;
	logic               clkStart;
	logic               syncEvt;
	logic               waitSync;
	logic               alignEvt;
	logic               perEnd;
	logic [1:0]         slot;
	logic [3:0]         rdIdx;
	logic [4:0]         triStep;
	logic [4:0]         triLvl;
	logic [7:0]         dev;
	logic [7:0]         slotOff;
	logic [7:0]         half;
	logic [7:0]         perNext;
	logic [8:0]         cntB;
	logic signed [15:0] offProd;
	poc_pkg::poc_pm_t   pmReq;
	logic [7:0]         chCnt [2];
	logic [7:0]         chAmp [2];
	logic [1:0]         chPos;
	logic [1:0]         chNeg;

	always_comb begin
		pmReq    = poc_pkg::poc_pm_t'(st_r.regs.pwrReq[1:0]);
		mono     = st_r.regs.swCfg[`POC_B_MONO];
		ssOn     = st_r.regs.ssEn[1:0] == `POC_SS_ON;
		syncEn   = st_r.regs.phSel[1:0] == `POC_SYNC_ON;
		slot     = st_r.regs.phSel[3:2];
		pinSync  = st_r.regs.pinRt != 8'h00;
		syncRise = sync_input_pin && !st_r.syncPrev;
		clkStart = bitClkOn && !st_r.clkPrev;
		// a routed sync pin takes over from the bit clock restart
		syncEvt  = pinSync ? syncRise : clkStart;
		waitSync = syncEn
			&& (pmReq == poc_pkg::PM_PLAY)
			&& (st_r.pm != poc_pkg::PM_PLAY);
		alignEvt = syncEn && syncEvt && (st_r.pm == poc_pkg::PM_HIZ);
		dev      = devOf(st_r.regs.ssRate[1:0]);
		triStep  = st_r.regs.ssRate[`POC_B_FASTTRI] ? 5'h02 : 5'h01;
		slotOff  = 8'((32'(slot) * `POC_PER_CYC) / `POC_SLOTS);
		half     = {1'b0, st_r.perLen[7:1]};
		perEnd   = st_r.cnt >= (st_r.perLen - 8'h01);
		triLvl   = st_r.triPh[4] ? 5'(6'h20 - {1'b0, st_r.triPh}) : st_r.triPh;
		offProd  = 16'(($signed({11'h000, triLvl}) - 16'(`POC_TRI_MID))
			* $signed({8'h00, dev}));
		// period deviates by at most dev either side of the centre
		if (ssOn) begin
			perNext = 8'(16'(`POC_PER_CYC) + (offProd >>> 3));
		end else begin
			perNext = 8'(`POC_PER_CYC);
		end
		cntB     = {1'b0, st_r.cnt} + {1'b0, half};
		if (cntB >= {1'b0, st_r.perLen}) begin
			cntB = cntB - {1'b0, st_r.perLen};
		end
		chCnt[0] = st_r.cnt;
		chCnt[1] = st_r.regs.loopPh[`POC_B_CHSHIFT] ? cntB[7:0] : st_r.cnt;
		chAmp[0] = st_r.ampA;
		chAmp[1] = st_r.ampB;
		rdIdx    = regIdx(regAddr);
	end

	// both outputs of a channel start high together; amplitude splits the duty
	for (genvar g = 0; g < 2; g++) begin : gen_chan
		logic signed [9:0] posDuty;
		logic signed [9:0] negDuty;
		assign posDuty  = $signed({2'h0, half}) + $signed({{2{chAmp[g][7]}}, chAmp[g]});
		assign negDuty  = $signed({2'h0, half}) - $signed({{2{chAmp[g][7]}}, chAmp[g]});
		assign chPos[g] = $signed({2'h0, chCnt[g]}) < posDuty;
		assign chNeg[g] = $signed({2'h0, chCnt[g]}) < negDuty;
	end

	always_comb begin
		st_nxt          = st_r;
		st_nxt.syncPrev = sync_input_pin;
		st_nxt.clkPrev  = bitClkOn;
		if (regWr) begin
			if (rdIdx == 4'h0) begin
				st_nxt.regs.swCfg = regWrData;
			end else if (rdIdx == 4'h1) begin
				st_nxt.regs.pwrReq = regWrData;
			end else if (rdIdx == 4'h2) begin
				st_nxt.regs.loopPh = regWrData;
			end else if (rdIdx == 4'h3) begin
				st_nxt.regs.pinFn = regWrData;
			end else if (rdIdx == 4'h4) begin
				st_nxt.regs.pinRt = regWrData;
			end else if (rdIdx == 4'h5) begin
				st_nxt.regs.phSel = regWrData;
			end else if (rdIdx == 4'h6) begin
				st_nxt.regs.ssEn = regWrData;
			end else if (rdIdx == 4'h7) begin
				st_nxt.regs.ssRate = regWrData;
			end
		end
		if (regRd) begin
			st_nxt.rdData = rdMux(st_r.regs, st_r.pm, rdIdx);
		end
		// a synchronised play request parks in hiz until the shared event
		if (waitSync) begin
			if (syncEvt && (st_r.pm == poc_pkg::PM_HIZ)) begin
				st_nxt.pm = poc_pkg::PM_PLAY;
			end else begin
				st_nxt.pm = poc_pkg::PM_HIZ;
			end
		end else begin
			st_nxt.pm = pmReq;
		end
		if (alignEvt) begin
			st_nxt.cnt   = slotOff;
			st_nxt.triPh = 5'h00;
		end else if (perEnd) begin
			st_nxt.cnt    = 8'h00;
			st_nxt.perLen = perNext;
			st_nxt.triPh  = 5'(st_r.triPh + triStep);
			// samples are held for a whole carrier period to keep pulses clean
			st_nxt.ampA   = ampOf(leftSample);
			if (mono) begin
				st_nxt.ampB = ampOf(leftSample);
			end else begin
				st_nxt.ampB = ampOf(rightSample);
			end
		end else begin
			st_nxt.cnt = 8'(st_r.cnt + 8'h01);
		end
		if (st_nxt.pm == poc_pkg::PM_PLAY) begin
			st_nxt.out.drvEn = 2'h3;
		end else begin
			st_nxt.out.drvEn = 2'h0;
		end
		st_nxt.out.positive_output = chPos & st_nxt.out.drvEn;
		st_nxt.out.negative_output = chNeg & st_nxt.out.drvEn;
	end

	always_ff @(posedge sys_clk or negedge rstOk) begin
		if (!rstOk) begin
			st_r <= ST_RST;
		end else if (clkEn) begin
			st_r <= st_nxt;
		end
	end

	assign pwmOut     = st_r.out;
	assign powerState = st_r.pm;
	assign regRdData  = st_r.rdData;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstOk || !clkEn);

	chk_drv_idle: assert property (
		st_r.pm != poc_pkg::PM_PLAY |-> st_r.out.drvEn == 2'h0
			&& st_r.out.positive_output == 2'h0 && st_r.out.negative_output == 2'h0
	) else $error("output drivers enabled outside play");

	chk_zero_phase: assert property (
		st_r.out.drvEn[0] && $past(st_r.ampA) == 8'h00
			|-> st_r.out.positive_output[0] == st_r.out.negative_output[0]
	) else $error("outputs not in phase at zero input");

	chk_pos_wider: assert property (
		st_r.out.drvEn[0] && !$past(st_r.ampA[7]) && $past(st_r.ampA) != 8'h00
			&& st_r.out.negative_output[0] |-> st_r.out.positive_output[0]
	) else $error("positive value without wider positive pulse");

	chk_neg_wider: assert property (
		st_r.out.drvEn[0] && $past(st_r.ampA[7])
			&& st_r.out.positive_output[0] |-> st_r.out.negative_output[0]
	) else $error("negative value without wider negative pulse");

	chk_fixed_period: assert property (
		perEnd && !ssOn && !alignEvt |=> st_r.perLen == 8'(`POC_PER_CYC)
	) else $error("carrier period moved with spread off");

	chk_spread_bound: assert property (
		perEnd && ssOn && !alignEvt
			|=> (st_r.perLen <= 8'(`POC_PER_CYC) + $past(dev))
			&& (st_r.perLen + $past(dev) >= 8'(`POC_PER_CYC))
	) else $error("spread period outside its range");

	chk_sync_hold: assert property (
		waitSync && !alignEvt |=> st_r.pm == poc_pkg::PM_HIZ
	) else $error("left hiz before the sync event");

	chk_sync_play: assert property (
		waitSync && alignEvt |=> st_r.pm == poc_pkg::PM_PLAY && st_r.cnt == $past(slotOff)
	) else $error("sync event did not start play at the slot");

	chk_mono_src: assert property (
		perEnd && mono && !alignEvt |=> st_r.ampB == st_r.ampA
	) else $error("mono outputs not fed from one source");

	cov_pin_sync: cover property (waitSync && alignEvt && pinSync);
	cov_clk_sync: cover property (waitSync && alignEvt && !pinSync);
	cov_spread: cover property (perEnd && ssOn && st_r.perLen != 8'(`POC_PER_CYC));
endmodule

// *** rtl/poc_pkg.sv ***
// types of the pwm output controller
package poc_pkg;
	typedef enum logic [1:0] {
		PM_DEEP  = 2'b00,
		PM_SLEEP = 2'b01,
		PM_HIZ   = 2'b10,
		PM_PLAY  = 2'b11
	} poc_pm_t;

	typedef struct packed {
		logic [7:0] swCfg;
		logic [7:0] pwrReq;
		logic [7:0] loopPh;
		logic [7:0] pinFn;
		logic [7:0] pinRt;
		logic [7:0] phSel;
		logic [7:0] ssEn;
		logic [7:0] ssRate;
	} poc_regs_t;

	typedef struct packed {
		logic [1:0] positive_output;
		logic [1:0] negative_output;
		logic [1:0] drvEn;
	} poc_out_t;

	typedef struct packed {
		poc_regs_t  regs;
		poc_pm_t    pm;
		logic [7:0] cnt;
		logic [4:0] triPh;
		logic [7:0] perLen;
		logic [7:0] ampA;
		logic [7:0] ampB;
		logic       syncPrev;
		logic       clkPrev;
		logic [7:0] rdData;
		poc_out_t   out;
	} poc_state_t;
endpackage

// *** testbench/poc_load.sv ***
// speaker load model tallying channel a drive time
`timescale 1ns/10ps
module poc_load (
	input  wire logic              sys_clk, // clock
	input  wire logic              clr,     // restart tallies
	input  wire poc_pkg::poc_out_t pins,    // driven pins
	output int                     posHigh, // positive high cycles
	output int                     negHigh  // negative high cycles
);
	// a released pin draws no current, so it adds nothing
	always @(posedge sys_clk) begin
		posHigh <= clr ? 0 : posHigh + int'(pins.drvEn[0] & pins.positive_output[0]);
		negHigh <= clr ? 0 : negHigh + int'(pins.drvEn[0] & pins.negative_output[0]);
	end
endmodule

// *** testbench/tb_pwm_output_mode_control.sv ***
// random and corner stimulus for the pwm output controller
`timescale 1ns/10ps
`include "poc_consts.svh"
module tb_pwm_output_mode_control;
	logic              sys_clk = 0, rstn = 0, regWr = 0, regRd = 0, sync = 0, clr = 1;
	logic              bclk = 1;
	logic [7:0]        regAddr = 0, regWrData = 0, rdv, d;
	logic [15:0]       leftS = 0, rightS = 0;
	logic [31:0]       seed = 32'hC8E58898;
	int                mismatches = 0, samples_checked = 0, posHigh, negHigh, i;
	poc_pkg::poc_out_t pwmOut;
	poc_pkg::poc_pm_t  powerState;
	logic [7:0]        ra [5] = '{8'h02, 8'h53, 8'h60, 8'h64, 8'h6C};
	poc_pkg::poc_pm_t  pm [5] = '{poc_pkg::PM_DEEP, poc_pkg::PM_PLAY, poc_pkg::PM_SLEEP,
		poc_pkg::PM_HIZ, poc_pkg::PM_PLAY};
	always #5 sys_clk = ~sys_clk;
	poc_core dut (.sys_clk(sys_clk), .rstn(rstn), .clkEn(1'b1), .regWr(regWr), .regRd(regRd),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(rdv), .leftSample(leftS),
		.rightSample(rightS), .bitClkOn(bclk), .sync_input_pin(sync), .pwmOut(pwmOut),
		.powerState(powerState));
	poc_load load (.sys_clk(sys_clk), .clr(clr), .pins(pwmOut), .posHigh(posHigh),
		.negHigh(negHigh));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		@(negedge sys_clk);
		chk(rdv, exp);
	endtask
	task automatic waitSt(input poc_pkg::poc_pm_t s);
		for (i = 0; i < 3000 && powerState !== s; i++)
			@(negedge sys_clk);
		chk({6'h00, powerState}, {6'h00, s});
		if (powerState !== s)
			summarize();
	endtask
	// tally over 8 nominal carrier periods so the spread of one edge cannot tip it
	task automatic duty(input logic [15:0] s, input logic [7:0] exp);
		@(posedge sys_clk);
		leftS <= s;
		rightS <= 16'(rnd());
		clr <= 1'b1;
		repeat (2 * `POC_PER_CYC) @(posedge sys_clk);
		clr <= 1'b0;
		repeat (8 * `POC_PER_CYC) @(posedge sys_clk);
		chk({6'h00, posHigh > negHigh, posHigh < negHigh}, exp);
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		foreach (ra[k]) begin
			d = 8'(rnd());
			wr(ra[k], d);
			rd(ra[k], d);
			wr(ra[k], 8'h00);
		end
		foreach (pm[k]) begin
			wr(`POC_A_PWRREQ, {6'h00, pm[k]});
			waitSt(pm[k]);
			rd(`POC_A_STATE, {6'h00, pm[k]});
			chk({7'h00, pwmOut.drvEn != 2'b00}, {7'h00, pm[k] == poc_pkg::PM_PLAY});
		end
		wr(`POC_A_SSEN, 8'h03);
		wr(`POC_A_SSRATE, 8'h01);
		duty(16'h0000, 8'h00);
		duty(16'(rnd()) & 16'h7FFF | 16'h1000, 8'h02);
		duty((16'(rnd()) | 16'h8000) & 16'hEFFF, 8'h01);
		wr(`POC_A_PWRREQ, 8'h02);
		waitSt(poc_pkg::PM_HIZ);
		wr(`POC_A_PINFN, 8'h01);
		wr(`POC_A_PINRT, 8'h01);
		wr(`POC_A_PHSEL, 8'h07);
		wr(`POC_A_PWRREQ, 8'h03);
		repeat (50) @(posedge sys_clk);
		rd(`POC_A_STATE, 8'h02);
		@(posedge sys_clk);
		sync <= 1'b1;
		waitSt(poc_pkg::PM_PLAY);
		wr(`POC_A_PINRT, 8'h00);
		waitSt(poc_pkg::PM_PLAY);
		wr(`POC_A_PWRREQ, 8'h02);
		waitSt(poc_pkg::PM_HIZ);
		@(posedge sys_clk);
		bclk <= 1'b0;
		wr(`POC_A_PHSEL, 8'h0B);
		wr(`POC_A_PWRREQ, 8'h03);
		repeat (20) @(posedge sys_clk);
		rd(`POC_A_STATE, 8'h02);
		@(posedge sys_clk);
		bclk <= 1'b1;
		waitSt(poc_pkg::PM_PLAY);
		summarize();
	end
endmodule
